// ==== hdl/lcdmd_pkg.sv ====
// shared constants for the lcd matrix driver link, device end and host end
package lcdmd_pkg;
    // ----------------------------------------
    // display geometry and word layout
    // ----------------------------------------
    localparam int          ROWS          = 16;
    localparam int          COLS          = 64;
    localparam int          ROW_W         = 4;
    localparam int          SUB_W         = 2;
    localparam int          ADDR_W        = 8;
    localparam int          LVL_W         = 2;
    localparam int          ADDR_CHIP_HI  = 5;
    localparam int          ADDR_CHIP_LO  = 4;
    localparam int          ADDR_ROW_HI   = 3;
    localparam int          ADDR_ROW_LO   = 0;
    localparam logic [1:0]  SUB_LAST      = 2'h3;
    localparam logic [3:0]  ROW_LAST      = 4'hF;
    localparam logic [3:0]  ROW_FIRST     = 4'h0;
    // ----------------------------------------
    // output level codes
    // ----------------------------------------
    localparam logic [1:0]  COM_VDSP      = 2'h0;
    localparam logic [1:0]  COM_V1        = 2'h1;
    localparam logic [1:0]  COM_V4        = 2'h2;
    localparam logic [1:0]  COM_GND       = 2'h3;
    localparam logic [1:0]  SEG_VDSP      = 2'h0;
    localparam logic [1:0]  SEG_V2        = 2'h1;
    localparam logic [1:0]  SEG_V3        = 2'h2;
    localparam logic [1:0]  SEG_GND       = 2'h3;
    // ----------------------------------------
    // host command registers
    // ----------------------------------------
    localparam int          REG_AW        = 8;
    localparam int          REG_DW        = 32;
    localparam logic [7:0]  REG_CTRL      = 8'h00;
    localparam logic [7:0]  REG_ADDR      = 8'h04;
    localparam logic [7:0]  REG_SEG_LO    = 8'h08;
    localparam logic [7:0]  REG_SEG_HI    = 8'h0C;
    localparam logic [7:0]  REG_STATUS    = 8'h10;
    localparam int          CTRL_POR_BIT  = 0;
    localparam int          CTRL_BLK_BIT  = 1;
    localparam logic [1:0]  CTRL_RESET    = 2'h3;
    localparam int          STAT_BUSY_BIT = 0;
    localparam int          STAT_ADDR_BIT = 1;
    // ----------------------------------------
    // serial timing
    // ----------------------------------------
    localparam int          CLK_NS        = 10;
    localparam int          SCK_HALF_NS   = 1000;
    localparam int          SETUP_NS      = 1000;
    localparam int          LATCH_NS      = 15000;
    localparam int          SCK_HALF_CYC  = (SCK_HALF_NS + CLK_NS - 1) / CLK_NS;
    localparam int          SETUP_CYC     = (SETUP_NS + CLK_NS - 1) / CLK_NS;
    localparam int          LATCH_CYC     = (LATCH_NS + CLK_NS - 1) / CLK_NS;
    localparam int          TMR_W         = 12;
    localparam int          CNT_W         = 7;
endpackage : lcdmd_pkg

// ==== hdl/lcdmd_if.sv ====
// serial link between host controller and driver chips
`timescale 1ns/1ns
interface lcdmd_if;
    logic sck;
    logic si;
    logic latch;
    logic addr_sel;
    logic por;
    logic blank;
    modport host (output sck, output si, output latch, output addr_sel, output por, output blank);
    modport dev  (input sck, input si, input latch, input addr_sel, input por, input blank);
endinterface : lcdmd_if

// ==== hdl/lcdmd_sync.sv ====
// two-flop synchroniser for a group of asynchronous inputs
`timescale 1ns/1ns
module lcdmd_sync #(
    parameter int               W   = 1,
    parameter logic [W-1:0]     RST = '0
) (
    input  wire logic           ref_clk,
    input  wire logic           resetn,
    input  wire logic [W-1:0]   d,
    output logic      [W-1:0]   q
);
    logic [W-1:0] meta_reg;

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            meta_reg <= RST;
            q        <= RST;
        end else begin
            meta_reg <= d;
            q        <= meta_reg;
        end
    end
endmodule : lcdmd_sync

// ==== hdl/lcdmd_dev.sv ====
// driver chip end: serial input, display ram, row scan and level selection
//
// Implementation choices: the address map and the strobed register port.
`timescale 1ns/1ns
module lcdmd_dev (
    input  wire logic           ref_clk,
    input  wire logic           resetn,
    lcdmd_if.dev                link,
    input  wire logic           chip_strap_low,
    input  wire logic           chip_strap_high,
    input  wire logic           osc_input,
    output logic                osc_out,
    input  wire logic           frame_sync_in,
    output logic                frame_sync_out,
    output logic                frame_sync_oe_n,
    output logic [31:0]         common_outputs,
    output logic [127:0]        segment_outputs
);
    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        logic [63:0]    shift;
        logic [7:0]     addr;
        logic           addr_ok;
        logic           sck_prev;
        logic           osc_prev;
        logic           fs_prev;
        logic           por_prev;
        logic           blank_prev;
        logic [1:0]     sub;
        logic [3:0]     row;
        logic           phase;
        logic           pend;
        logic           fs_out;
        logic           fs_oe_n;
        logic           osc_out;
        logic           wr_en;
        logic [3:0]     wr_row;
        logic [63:0]    wr_data;
        logic [31:0]    com;
        logic [127:0]   seg;
    } lcdmd_dev_st_t;

    localparam lcdmd_dev_st_t ST_RESET = '{
        shift: '0, addr: '0, addr_ok: 1'b0, sck_prev: 1'b1, osc_prev: 1'b0, fs_prev: 1'b0,
        por_prev: 1'b1, blank_prev: 1'b1, sub: '0, row: lcdmd_pkg::ROW_FIRST, phase: 1'b0,
        pend: 1'b0, fs_out: 1'b0, fs_oe_n: 1'b1, osc_out: 1'b0, wr_en: 1'b0, wr_row: '0,
        wr_data: '0, com: {lcdmd_pkg::ROWS{lcdmd_pkg::COM_V4}},
        seg: {lcdmd_pkg::COLS{lcdmd_pkg::SEG_V3}}};

    lcdmd_dev_st_t  st_reg;
    lcdmd_dev_st_t  st_next;
    logic [63:0]    ram [lcdmd_pkg::ROWS];
    logic [9:0]     s_in;
    logic           s_sck, s_si, s_latch, s_asel, s_por, s_blank;
    logic           s_strl, s_strh, s_osc, s_fs;

    // ----------------------------------------
    // input synchronisers
    // ----------------------------------------
    lcdmd_sync #(.W(10), .RST(10'h37C)) u_sync (
        .ref_clk (ref_clk),
        .resetn  (resetn),
        .d       ({link.sck, link.si, link.latch, link.addr_sel, link.por, link.blank,
                   chip_strap_low, chip_strap_high, osc_input, frame_sync_in}),
        .q       (s_in)
    );
    assign {s_sck, s_si, s_latch, s_asel, s_por, s_blank, s_strl, s_strh, s_osc, s_fs} = s_in;

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        logic           master;
        logic           sck_rise;
        logic           tick;
        logic [7:0]     aw;
        logic [63:0]    row_data;
        logic           sel;
        logic           fall;
        master   = !s_strl && !s_strh;
        fall     = (st_reg.por_prev && !s_por) || (st_reg.blank_prev && !s_blank);
        sck_rise = s_sck && !st_reg.sck_prev;
        tick     = s_osc && !st_reg.osc_prev;
        aw       = '0;
        row_data = ram[st_reg.row];
        sel      = 1'b0;
        st_next  = st_reg;
        st_next.sck_prev   = s_sck;
        st_next.osc_prev   = s_osc;
        st_next.fs_prev    = s_fs;
        st_next.por_prev   = s_por;
        st_next.blank_prev = s_blank;
        st_next.wr_en      = 1'b0;
        if (sck_rise) begin
            st_next.shift = {st_reg.shift[62:0], s_si};
        end
        if (s_latch && !s_por) begin
            if (s_asel) begin
                for (int i = 0; i < lcdmd_pkg::ADDR_W; i++) begin
                    aw[i] = st_reg.shift[lcdmd_pkg::ADDR_W-1-i];
                end
                st_next.addr    = aw;
                st_next.addr_ok = aw[lcdmd_pkg::ADDR_CHIP_HI:lcdmd_pkg::ADDR_CHIP_LO]
                                  == {s_strh, s_strl};
            end else if (st_reg.addr_ok) begin
                st_next.wr_en   = 1'b1;
                st_next.wr_row  = st_reg.addr[lcdmd_pkg::ADDR_ROW_HI:lcdmd_pkg::ADDR_ROW_LO];
                st_next.wr_data = st_reg.shift;
            end
        end
        if (fall) begin
            st_next.pend = 1'b1;
        end
        if (!master && (s_fs != st_reg.fs_prev)) begin
            st_next.row   = lcdmd_pkg::ROW_FIRST;
            st_next.sub   = '0;
            st_next.phase = s_fs;
            st_next.pend  = fall;
        end else if (tick && !s_por) begin
            if (st_reg.pend) begin
                st_next.row    = lcdmd_pkg::ROW_FIRST;
                st_next.sub    = '0;
                st_next.pend   = fall;
                st_next.phase  = !st_reg.phase;
                st_next.fs_out = !st_reg.fs_out;
            end else begin
                st_next.sub = st_reg.sub + 2'h1;
                if (st_reg.sub == lcdmd_pkg::SUB_LAST) begin
                    st_next.row = st_reg.row + 4'h1;
                    if (st_reg.row == lcdmd_pkg::ROW_LAST) begin
                        st_next.phase  = !st_reg.phase;
                        st_next.fs_out = !st_reg.fs_out;
                    end
                end
            end
        end
        st_next.fs_oe_n = !master;
        st_next.osc_out = master && s_osc;
        for (int c = 0; c < lcdmd_pkg::ROWS; c++) begin
            sel = st_reg.row == 4'(c);
            if (s_por) begin
                st_next.com[2*c +: 2] = lcdmd_pkg::COM_V4;
            end else if (sel) begin
                st_next.com[2*c +: 2] = st_reg.phase ? lcdmd_pkg::COM_GND
                                                     : lcdmd_pkg::COM_VDSP;
            end else begin
                st_next.com[2*c +: 2] = st_reg.phase ? lcdmd_pkg::COM_V4
                                                     : lcdmd_pkg::COM_V1;
            end
        end
        for (int s = 0; s < lcdmd_pkg::COLS; s++) begin
            if (s_por) begin
                st_next.seg[2*s +: 2] = lcdmd_pkg::SEG_V3;
            end else if (s_blank || !row_data[s]) begin
                st_next.seg[2*s +: 2] = st_reg.phase ? lcdmd_pkg::SEG_V3
                                                     : lcdmd_pkg::SEG_V2;
            end else begin
                st_next.seg[2*s +: 2] = st_reg.phase ? lcdmd_pkg::SEG_GND
                                                     : lcdmd_pkg::SEG_VDSP;
            end
        end
    end

    // ----------------------------------------
    // registers and display ram
    // ----------------------------------------
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            st_reg <= ST_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (st_reg.wr_en) begin
            ram[st_reg.wr_row] <= st_reg.wr_data;
        end
    end

    assign osc_out         = st_reg.osc_out;
    assign frame_sync_out  = st_reg.fs_out;
    assign frame_sync_oe_n = st_reg.fs_oe_n;
    assign common_outputs  = st_reg.com;
    assign segment_outputs = st_reg.seg;
endmodule : lcdmd_dev

// ==== hdl/lcdmd_host.sv ====
// host end: register port driving the serial link to all driver chips
`timescale 1ns/1ns
module lcdmd_host (
    input  wire logic           ref_clk,
    input  wire logic           resetn,
    lcdmd_if.host               link,
    input  wire logic [7:0]     reg_addr,
    input  wire logic [31:0]    reg_wdata,
    input  wire logic           reg_wr,
    input  wire logic           reg_rd,
    output logic [31:0]         reg_rdata
);
    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef enum logic [2:0] {H_IDLE, H_SETUP, H_LOW, H_HIGH, H_GAP, H_LATCH, H_HOLD} lcdmd_hst_t;

    typedef struct packed {
        lcdmd_hst_t     state;
        logic [1:0]     ctrl;
        logic [63:0]    seg;
        logic [7:0]     addr;
        logic [63:0]    shift;
        logic [6:0]     bits;
        logic           is_addr;
        logic           addr_loaded;
        logic [11:0]    timer;
        logic           sck;
        logic           si;
        logic           latch;
        logic           asel;
        logic [31:0]    rdata;
    } lcdmd_host_st_t;

    localparam logic [11:0] T_HALF  = 12'(lcdmd_pkg::SCK_HALF_CYC - 1);
    localparam logic [11:0] T_SETUP = 12'(lcdmd_pkg::SETUP_CYC - 1);
    localparam logic [11:0] T_LATCH = 12'(lcdmd_pkg::LATCH_CYC - 1);

    lcdmd_host_st_t st_reg;
    lcdmd_host_st_t st_next;

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        logic busy;
        logic done;
        busy    = st_reg.state != H_IDLE;
        done    = st_reg.timer == 12'h000;
        st_next = st_reg;
        st_next.rdata = '0;
        if (!done) begin
            st_next.timer = st_reg.timer - 12'h001;
        end
        if (reg_rd) begin
            case (reg_addr)
                lcdmd_pkg::REG_CTRL:   st_next.rdata = {30'h0, st_reg.ctrl};
                lcdmd_pkg::REG_ADDR:   st_next.rdata = {24'h0, st_reg.addr};
                lcdmd_pkg::REG_SEG_LO: st_next.rdata = st_reg.seg[31:0];
                lcdmd_pkg::REG_SEG_HI: st_next.rdata = st_reg.seg[63:32];
                lcdmd_pkg::REG_STATUS: st_next.rdata = {30'h0, st_reg.addr_loaded, busy};
                default:               st_next.rdata = '0;
            endcase
        end
        if (reg_wr) begin
            case (reg_addr)
                lcdmd_pkg::REG_CTRL: begin
                    st_next.ctrl = reg_wdata[1:0];
                end
                lcdmd_pkg::REG_SEG_LO: begin
                    st_next.seg[31:0] = reg_wdata;
                end
                lcdmd_pkg::REG_ADDR: begin
                    if (!busy) begin
                        st_next.addr    = reg_wdata[7:0];
                        st_next.shift   = {56'h0, reg_wdata[7:0]};
                        st_next.bits    = 7'(lcdmd_pkg::ADDR_W);
                        st_next.is_addr = 1'b1;
                        st_next.asel    = 1'b1;
                        st_next.timer   = T_SETUP;
                        st_next.state   = H_SETUP;
                    end
                end
                lcdmd_pkg::REG_SEG_HI: begin
                    st_next.seg[63:32] = reg_wdata;
                    if (!busy && st_reg.addr_loaded) begin
                        st_next.shift   = {reg_wdata, st_reg.seg[31:0]};
                        st_next.bits    = 7'(lcdmd_pkg::COLS);
                        st_next.is_addr = 1'b0;
                        st_next.asel    = 1'b0;
                        st_next.timer   = T_SETUP;
                        st_next.state   = H_SETUP;
                    end
                end
                default: begin
                end
            endcase
        end
        case (st_reg.state)
            H_IDLE: begin
            end
            H_SETUP: begin
                if (done) begin
                    st_next.state = H_LOW;
                    st_next.sck   = 1'b0;
                    st_next.si    = st_reg.is_addr ? st_reg.shift[0]
                                                   : st_reg.shift[63];
                    st_next.timer = T_HALF;
                end
            end
            H_LOW: begin
                if (done) begin
                    st_next.state = H_HIGH;
                    st_next.sck   = 1'b1;
                    st_next.timer = T_HALF;
                end
            end
            H_HIGH: begin
                if (done) begin
                    st_next.shift = st_reg.is_addr ? {1'b0, st_reg.shift[63:1]}
                                                   : {st_reg.shift[62:0], 1'b0};
                    st_next.bits  = st_reg.bits - 7'h01;
                    st_next.timer = T_HALF;
                    if (st_reg.bits == 7'h01) begin
                        st_next.state = H_GAP;
                    end else begin
                        st_next.state = H_LOW;
                        st_next.sck   = 1'b0;
                        st_next.si    = st_reg.is_addr ? st_reg.shift[1]
                                                       : st_reg.shift[62];
                    end
                end
            end
            H_GAP: begin
                if (done) begin
                    st_next.state = H_LATCH;
                    st_next.latch = 1'b1;
                    st_next.timer = T_LATCH;
                end
            end
            H_LATCH: begin
                if (done) begin
                    st_next.state = H_HOLD;
                    st_next.latch = 1'b0;
                    st_next.timer = T_SETUP;
                end
            end
            H_HOLD: begin
                if (done) begin
                    st_next.state = H_IDLE;
                    if (st_reg.is_addr) begin
                        st_next.addr_loaded = 1'b1;
                    end
                end
            end
            default: begin
                st_next.state = H_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            st_reg <= '{state: H_IDLE, ctrl: lcdmd_pkg::CTRL_RESET, seg: '0, addr: '0,
                        shift: '0, bits: '0, is_addr: 1'b0, addr_loaded: 1'b0, timer: '0,
                        sck: 1'b1, si: 1'b1, latch: 1'b0, asel: 1'b1, rdata: '0};
        end else begin
            st_reg <= st_next;
        end
    end

    // ----------------------------------------
    // link pins, shared by every chip
    // ----------------------------------------
    assign link.sck      = st_reg.sck;
    assign link.si       = st_reg.si;
    assign link.latch    = st_reg.latch;
    assign link.addr_sel = st_reg.asel;
    assign link.por      = st_reg.ctrl[lcdmd_pkg::CTRL_POR_BIT];
    assign link.blank    = st_reg.ctrl[lcdmd_pkg::CTRL_BLK_BIT];
    assign reg_rdata     = st_reg.rdata;
endmodule : lcdmd_host

// ==== testbench/lcdmd_chk.sv ====
// concurrent checks on the host link and the master chip outputs
`timescale 1ns/1ns
module lcdmd_chk (
    input  wire logic           ref_clk,
    input  wire logic           resetn,
    input  wire logic           sck,
    input  wire logic           si,
    input  wire logic           latch,
    input  wire logic           addr_sel,
    input  wire logic           por,
    input  wire logic           blank,
    input  wire logic           frame_sync_oe_n,
    input  wire logic [31:0]    common_outputs,
    input  wire logic [127:0]   segment_outputs
);
    // ----------------------------------------
    // helper logic and properties
    // ----------------------------------------
    logic [11:0] hi_reg;
    logic        segs_off;
    logic [4:0]  sel_cnt;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            hi_reg <= 12'h000;
        end else begin
            hi_reg <= latch ? hi_reg + 12'h001 : 12'h000;
        end
    end
    always_comb begin
        sel_cnt = 5'h00;
        segs_off = 1'b1;
        for (int i = 0; i < 16; i++) begin
            sel_cnt = sel_cnt + 5'(common_outputs[2*i+:2] inside {2'h0, 2'h3});
        end
        for (int i = 0; i < 64; i++) begin
            if (segment_outputs[2*i+:2] inside {2'h0, 2'h3}) begin
                segs_off = 1'b0;
            end
        end
    end
    a_latch_sck_idle: assert property (latch |-> sck && $stable(addr_sel))
        else $error("latch high while shifting");
    a_latch_width: assert property ($fell(latch) |-> hi_reg == 12'(lcdmd_pkg::LATCH_CYC))
        else $error("latch pulse width wrong");
    a_sck_low_half: assert property ($fell(sck) |-> ##100 $rose(sck))
        else $error("shift clock low half wrong");
    a_si_setup: assert property (((!sck && !$fell(sck)) || $rose(sck)) |-> $stable(si))
        else $error("serial data moved before rise");
    a_sel_steady: assert property (!sck |-> $stable(addr_sel))
        else $error("select moved while shifting");
    a_por_static: assert property (por && $past(por, 4) |->
        segment_outputs == {64{lcdmd_pkg::SEG_V3}} && common_outputs == {16{lcdmd_pkg::COM_V4}})
        else $error("reset levels wrong");
    a_blank_off: assert property (blank && $past(blank, 4) |-> segs_off)
        else $error("segment lit while blanked");
    a_master_oe: assert property ($past(resetn, 3) |-> !frame_sync_oe_n)
        else $error("master not driving sync");
    a_one_row: assert property (!por && !$past(por, 4) |-> sel_cnt == 5'h01)
        else $error("not exactly one common selected");
    c_addr_word: cover property ($fell(latch) && addr_sel);
    c_seg_word: cover property ($fell(latch) && !addr_sel);
    c_blank_fall: cover property ($fell(blank));
endmodule : lcdmd_chk

// ==== testbench/lcdmd_tb.sv ====
// testbench: host end and two chained driver chips on one link
`timescale 1ns/1ns
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin err_total++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, a, b); end end
module lcdmd_tb;
    // ----------------------------------------
    // wiring
    // ----------------------------------------
    logic         ref_clk, resetn, osc, wr, rd;
    logic [7:0]   addr;
    logic [31:0]  wdata, rdata, v;
    logic         m_osc, m_fs, m_oe, s_osc, s_fs, s_oe;
    logic [31:0]  m_com, s_com;
    logic [127:0] m_seg, s_seg;
    logic [63:0]  cap;
    int           err_total, total_checks, n;
    wire          fs_line = m_oe ? ~m_fs : m_fs;
    lcdmd_if lk();
    lcdmd_host lcdmd_host_i (.ref_clk, .resetn, .link(lk), .reg_addr(addr), .reg_wdata(wdata),
        .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata));
    lcdmd_dev lcdmd_dev_i (.ref_clk, .resetn, .link(lk), .chip_strap_low(1'b0),
        .chip_strap_high(1'b0), .osc_input(osc), .osc_out(m_osc), .frame_sync_in(fs_line),
        .frame_sync_out(m_fs), .frame_sync_oe_n(m_oe), .common_outputs(m_com),
        .segment_outputs(m_seg));
    lcdmd_dev lcdmd_dev_s_i (.ref_clk, .resetn, .link(lk), .chip_strap_low(1'b1),
        .chip_strap_high(1'b0), .osc_input(m_osc), .osc_out(s_osc), .frame_sync_in(fs_line),
        .frame_sync_out(s_fs), .frame_sync_oe_n(s_oe), .common_outputs(s_com),
        .segment_outputs(s_seg));
    lcdmd_chk lcdmd_chk_i (.ref_clk, .resetn, .sck(lk.sck), .si(lk.si), .latch(lk.latch),
        .addr_sel(lk.addr_sel), .por(lk.por), .blank(lk.blank), .frame_sync_oe_n(m_oe),
        .common_outputs(m_com), .segment_outputs(m_seg));
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    initial begin
        osc = 1'b0;
        #3;
        forever #40 osc = ~osc;
    end
    always @(posedge lk.sck) cap <= {cap[62:0], lk.si};
    function automatic logic on(input logic [1:0] c);
        return c inside {2'h0, 2'h3};
    endfunction : on
    // ----------------------------------------
    // register port and scenarios
    // ----------------------------------------
    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge ref_clk);
        wr <= 1'b0;
    endtask : wreg
    task automatic rreg(input logic [7:0] a, output logic [31:0] q);
        @(posedge ref_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge ref_clk);
        rd <= 1'b0;
        @(posedge ref_clk);
        q = rdata;
    endtask : rreg
    task automatic send(input logic [7:0] a, input logic [31:0] d);
        wreg(a, d);
        v = 32'h00000001;
        for (int i = 0; i < 20000 && v[0]; i++) rreg(lcdmd_pkg::REG_STATUS, v);
        `CHK(v[0], 1'b0)
    endtask : send
    task automatic wait_fs(input int lim);
        logic f;
        f = m_fs;
        n = 0;
        while (m_fs === f && n < lim) begin
            @(posedge ref_clk);
            n++;
        end
    endtask : wait_fs
    task automatic t_reset;
        rreg(lcdmd_pkg::REG_CTRL, v);
        `CHK(v, 32'h00000003)
        rreg(8'hFF, v);
        `CHK(v, 32'h00000000)
        repeat (10) @(posedge ref_clk);
        `CHK(m_seg, {64{lcdmd_pkg::SEG_V3}})
        `CHK(s_com, {16{lcdmd_pkg::COM_V4}})
        $display("test reset done");
    endtask : t_reset
    task automatic t_load;
        wreg(lcdmd_pkg::REG_CTRL, 32'h00000002);
        send(lcdmd_pkg::REG_ADDR, 32'h000000C5);
        `CHK(cap[7:0], 8'hA3)
        wreg(lcdmd_pkg::REG_SEG_LO, 32'hB4A59687);
        send(lcdmd_pkg::REG_SEG_HI, 32'hF0E1D2C3);
        `CHK(cap, 64'hF0E1D2C3B4A59687)
        send(lcdmd_pkg::REG_ADDR, 32'h00000015);
        wreg(lcdmd_pkg::REG_SEG_LO, 32'h89ABCDEF);
        send(lcdmd_pkg::REG_SEG_HI, 32'h01234567);
        wreg(lcdmd_pkg::REG_CTRL, 32'h00000003);
        wreg(lcdmd_pkg::REG_SEG_LO, 32'h00000000);
        send(lcdmd_pkg::REG_SEG_HI, 32'h00000000);
        $display("test load done");
    endtask : t_load
    task automatic t_scan;
        wreg(lcdmd_pkg::REG_CTRL, 32'h00000000);
        repeat (40) @(posedge ref_clk);
        for (int i = 0; i < 3000 && !on(m_com[11:10]); i++) @(posedge ref_clk);
        repeat (12) @(posedge ref_clk);
        `CHK(on(s_com[11:10]), 1'b1)
        for (int s = 0; s < 64; s++) begin
            `CHK(on(m_seg[2*s+:2]), 64'hF0E1D2C3B4A59687 >> s & 1'b1)
            `CHK(on(s_seg[2*s+:2]), 64'h0123456789ABCDEF >> s & 1'b1)
        end
        wait_fs(1000);
        wait_fs(1000);
        `CHK(n, 512)
        `CHK(s_oe, 1'b1)
        `CHK(s_osc, 1'b0)
        $display("test scan done");
    endtask : t_scan
    task automatic t_blank;
        wreg(lcdmd_pkg::REG_CTRL, 32'h00000002);
        repeat (600) @(posedge ref_clk);
        wreg(lcdmd_pkg::REG_CTRL, 32'h00000000);
        wait_fs(40);
        `CHK(n < 40, 1'b1)
        repeat (2) @(posedge ref_clk);
        `CHK(on(m_com[1:0]), 1'b1)
        repeat (32) @(posedge ref_clk);
        `CHK(on(m_com[3:2]), 1'b1)
        $display("test blank done");
    endtask : t_blank
    task automatic tally_and_finish;
        $display("checks=%0d mismatches=%0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : tally_and_finish
    initial begin
        #900000;
        err_total++;
        tally_and_finish();
    end
    initial begin
        resetn = 1'b0;
        wr = 1'b0;
        rd = 1'b0;
        addr = 8'h00;
        wdata = 32'h00000000;
        err_total = 0;
        total_checks = 0;
        repeat (12) @(posedge ref_clk);
        resetn <= 1'b1;
        t_reset();
        t_load();
        t_scan();
        t_blank();
        tally_and_finish();
    end
endmodule : lcdmd_tb
